// *** hw/fcr_map.svh ***
// register map, opcodes, bit positions and reset values of the config bank
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH

// opcodes
`define FCR_OP_RD_BANK_A 8'h16
`define FCR_OP_RD_BANK_B 8'hC8
`define FCR_OP_WR_BANK_V_A 8'h17
`define FCR_OP_WR_BANK_V_B 8'hC5
`define FCR_OP_WR_BANK_NV 8'h18
`define FCR_OP_ENTER_4B 8'hB7
`define FCR_OP_EXIT_4B 8'h29
`define FCR_OP_RD_PMODE 8'h2B
`define FCR_OP_PG_PMODE 8'h2F
`define FCR_OP_RD_BOOT 8'h14
`define FCR_OP_WR_BOOT 8'h15
`define FCR_OP_CLR_ERR 8'h82

// payload lengths in bytes
`define FCR_LEN_NONE 3'h0
`define FCR_LEN_BANK 3'h1
`define FCR_LEN_PMODE 3'h2
`define FCR_LEN_BOOT 3'h4
`define FCR_LEN_BAD 3'h7

// bank and address mode register
`define FCR_BA_SEG 0
`define FCR_BA_MODE 7
`define FCR_BANK_RST 8'h00

// protection mode register
`define FCR_PM_PST 1
`define FCR_PM_PWD 2
`define FCR_PM_TB 15
`define FCR_PM_RST 16'hFFFF
`define FCR_PM_NO_LOCK 2'h3
`define FCR_PM_BOTH_LOCK 2'h0

// boot read register
`define FCR_BOOT_RST 32'h0000_0000
`define FCR_BOOT_EN 0
`define FCR_BOOT_DLY_LO 1
`define FCR_BOOT_DLY_HI 4
`define FCR_BOOT_ADR_LO 5
`define FCR_DLY_DEFAULT 4'h0
`define FCR_DLY_FAST 4'h8
`define FCR_DLY_QUAD 4'h6

`endif

// *** hw/fcr_pkg.sv ***
// shared types of the flash config register bank
package fcr_pkg;

    typedef enum logic [1:0] {
        FR_OPCODE,
        FR_PAYLOAD,
        FR_READ,
        FR_IGNORE
    } fcr_frame_t;

    typedef struct packed {
        logic prot;
        logic prog;
        logic erase;
    } fcr_err_t;

endpackage

// *** hw/fcr_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fcr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule

// *** hw/fcr_top.sv ***
// flash config register bank: serial command decode and config registers
`timescale 1ns/1ps
`include "fcr_map.svh"

//  Contract
// - OTP bits program one way only; reverse attempts ignored, no error.
// - read-only and freeze-guarded bits silently keep value on writes.
// - error flags stay set until the clear-error-flags command.
// - hardware or software reset also clears the three error flags.
// - commands keep executing while error flags are set.
// - boot register upper bits hold 32-byte aligned start address, default 0.
// - boot delay uses fast read coding, or quad io coding when quad set.
// - boot delay field zero gives 8 cycles, or 6 with quad enable.
// - boot register bit 0 enables boot read, default disabled.
// - bank bit 0 selects upper 128Mb segment; reserved on 128Mb density.
// - in 3-byte mode bank value supplies address bits above 23.
// - in 4-byte mode bank ignored; host sends four address bytes.
// - bank bit 7 picks address length, default 0; bits 1-6 read-only.
// - decode bank read 16h/C8h, volatile write 17h/C5h, nv write 18h.
// - opcode B7h enters 4-byte mode, 29h leaves it.
// - protection register read 2Bh, program 2Fh, all ones default.
// - bit 1 zero permanently selects persistent protection mode.
// - bit 2 zero permanently selects password protection mode.
// - bit 15 zero puts parameter sectors top, one bottom.
// - programming both lock bits to zero aborts and flags program error.
// - protection error flag reports refused protected program or erase.
module fcr_top #(
    parameter bit DENSITY_128 = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic quad_enable_bit,
    input wire logic freeze_lock,
    input wire logic sw_reset,
    input wire fcr_pkg::fcr_err_t err_event,
    output fcr_pkg::fcr_err_t err_flags,
    output logic [26:0] boot_start_address,
    output logic [3:0] boot_start_delay,
    output logic [3:0] boot_delay_cycles,
    output logic boot_read_enable,
    output logic address_mode_bit,
    output logic upper_segment_select,
    output logic [7:0] upper_address_bits,
    output logic persistent_mode_lock,
    output logic password_mode_lock,
    output logic parameter_sector_location
);
    // ==========================================================
    // helpers
    function automatic logic [2:0] need_bytes(input logic [7:0] op);
        case (op)
            `FCR_OP_WR_BANK_V_A, `FCR_OP_WR_BANK_V_B,
            `FCR_OP_WR_BANK_NV: need_bytes = `FCR_LEN_BANK;
            `FCR_OP_PG_PMODE: need_bytes = `FCR_LEN_PMODE;
            `FCR_OP_WR_BOOT: need_bytes = `FCR_LEN_BOOT;
            `FCR_OP_ENTER_4B, `FCR_OP_EXIT_4B,
            `FCR_OP_CLR_ERR: need_bytes = `FCR_LEN_NONE;
            default: need_bytes = `FCR_LEN_BAD;
        endcase
    endfunction

    function automatic logic [2:0] read_bytes(input logic [7:0] op);
        case (op)
            `FCR_OP_RD_BANK_A,
            `FCR_OP_RD_BANK_B: read_bytes = `FCR_LEN_BANK;
            `FCR_OP_RD_PMODE: read_bytes = `FCR_LEN_PMODE;
            `FCR_OP_RD_BOOT: read_bytes = `FCR_LEN_BOOT;
            default: read_bytes = `FCR_LEN_NONE;
        endcase
    endfunction

    // writable bits of bank register; reserved bits keep zero
    function automatic logic [7:0] bank_wr(input logic [7:0] val);
        bank_wr = `FCR_BANK_RST;
        bank_wr[`FCR_BA_MODE] = val[`FCR_BA_MODE];
        if (!DENSITY_128) bank_wr[`FCR_BA_SEG] = val[`FCR_BA_SEG];
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [2:0] pins_s;
    logic sck_s;
    logic cs_n_s;
    logic si_s;

    fcr_sync #(.W(3), .INIT(3'h2)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .din({sck, cs_n, si}),
        .dout(pins_s)
    );

    assign sck_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign si_s = pins_s[0];

    // ==========================================================
    // serial frame decode
    fcr_pkg::fcr_frame_t st_q, st_d;
    logic sck_prev_q, sck_prev_d;
    logic [2:0] bit_q, bit_d;
    logic [2:0] nbytes_q, nbytes_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] op_q, op_d;
    logic [31:0] dat_q, dat_d;
    logic [4:0] rptr_q, rptr_d;
    logic so_q, so_d;
    logic oe_q, oe_d;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] sh_next;
    logic exec_ok;
    logic [31:0] rd_word;
    logic [4:0] rd_mask;
    logic [4:0] rd_idx;

    logic [7:0] bank_v_q, bank_v_d;
    logic [7:0] bank_nv_q, bank_nv_d;
    logic [15:0] pm_q, pm_d;
    logic [31:0] boot_q, boot_d;
    fcr_pkg::fcr_err_t err_q, err_d;
    logic [3:0] dly_q, dly_d;
    logic [7:0] addr_hi_q, addr_hi_d;

    always_comb begin
        sck_rise = sck_s & ~sck_prev_q & ~cs_n_s;
        sck_fall = ~sck_s & sck_prev_q & ~cs_n_s;
        sh_next = {sh_q[6:0], si_s};
        case (read_bytes(op_q))
            `FCR_LEN_BANK: rd_word = {24'h000000, bank_v_q};
            `FCR_LEN_PMODE: rd_word = {16'h0000, pm_q};
            default: rd_word = boot_q;
        endcase
        rd_mask = 5'({read_bytes(op_q), 3'h0} - 6'h01);
        rd_idx = {rptr_q[4:3], 3'h7 - rptr_q[2:0]};
        st_d = st_q;
        sck_prev_d = sck_s;
        bit_d = bit_q;
        nbytes_d = nbytes_q;
        sh_d = sh_q;
        op_d = op_q;
        dat_d = dat_q;
        rptr_d = rptr_q;
        so_d = so_q;
        oe_d = oe_q;
        exec_ok = 1'b0;
        if (cs_n_s) begin
            exec_ok = (st_q == fcr_pkg::FR_PAYLOAD) && (bit_q == 3'h0)
                && (nbytes_q == need_bytes(op_q));
            st_d = fcr_pkg::FR_OPCODE;
            bit_d = 3'h0;
            nbytes_d = 3'h0;
            rptr_d = 5'h00;
            oe_d = 1'b0;
            so_d = 1'b0;
        end else begin
            if (sck_rise) begin
                sh_d = sh_next;
                bit_d = bit_q + 3'h1;
            end
            case (st_q)
                fcr_pkg::FR_OPCODE: begin
                    if (sck_rise && bit_q == 3'h7) begin
                        op_d = sh_next;
                        if (read_bytes(sh_next) != `FCR_LEN_NONE) begin
                            st_d = fcr_pkg::FR_READ;
                        end else if (need_bytes(sh_next) != `FCR_LEN_BAD) begin
                            st_d = fcr_pkg::FR_PAYLOAD;
                        end else begin
                            st_d = fcr_pkg::FR_IGNORE;
                        end
                    end
                end
                fcr_pkg::FR_PAYLOAD: begin
                    if (sck_rise && bit_q == 3'h7) begin
                        if (nbytes_q < `FCR_LEN_BOOT) begin
                            dat_d[{nbytes_q[1:0], 3'h0} +: 8] = sh_next;
                        end
                        if (nbytes_q != `FCR_LEN_BAD) begin
                            nbytes_d = nbytes_q + 3'h1;
                        end
                    end
                end
                fcr_pkg::FR_READ: begin
                    if (sck_fall) begin
                        so_d = rd_word[rd_idx];
                        oe_d = 1'b1;
                        rptr_d = (rptr_q + 5'h01) & rd_mask;
                    end
                end
                default: st_d = fcr_pkg::FR_IGNORE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= fcr_pkg::FR_OPCODE;
            sck_prev_q <= 1'b0;
            bit_q <= 3'h0;
            nbytes_q <= 3'h0;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            dat_q <= 32'h0000_0000;
            rptr_q <= 5'h00;
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sck_prev_q <= sck_prev_d;
            bit_q <= bit_d;
            nbytes_q <= nbytes_d;
            sh_q <= sh_d;
            op_q <= op_d;
            dat_q <= dat_d;
            rptr_q <= rptr_d;
            so_q <= so_d;
            oe_q <= oe_d;
        end
    end

    // ==========================================================
    // configuration registers
    logic pm_fail;
    logic [1:0] lock_req;

    always_comb begin
        bank_v_d = bank_v_q;
        bank_nv_d = bank_nv_q;
        pm_d = pm_q;
        boot_d = boot_q;
        pm_fail = 1'b0;
        lock_req = dat_q[`FCR_PM_PWD:`FCR_PM_PST];
        if (sw_reset) begin
            bank_v_d = bank_nv_q;
        end
        if (exec_ok) begin
            case (op_q)
                `FCR_OP_WR_BANK_V_A, `FCR_OP_WR_BANK_V_B: begin
                    bank_v_d = bank_wr(dat_q[7:0]);
                end
                `FCR_OP_WR_BANK_NV: begin
                    bank_nv_d = bank_wr(dat_q[7:0]);
                    bank_v_d = bank_wr(dat_q[7:0]);
                end
                `FCR_OP_ENTER_4B: begin
                    bank_v_d[`FCR_BA_MODE] = 1'b1;
                end
                `FCR_OP_EXIT_4B: begin
                    bank_v_d[`FCR_BA_MODE] = 1'b0;
                end
                `FCR_OP_PG_PMODE: begin
                    // lock bits: one selection only, never both
                    if (lock_req != `FCR_PM_NO_LOCK) begin
                        if (lock_req == `FCR_PM_BOTH_LOCK) begin
                            pm_fail = 1'b1;
                        end else if (pm_q[`FCR_PM_PWD:`FCR_PM_PST]
                                != `FCR_PM_NO_LOCK) begin
                            pm_fail = 1'b1;
                        end
                    end
                    if (!pm_fail) begin
                        pm_d[`FCR_PM_PWD:`FCR_PM_PST] =
                            pm_q[`FCR_PM_PWD:`FCR_PM_PST] & lock_req;
                        if (!freeze_lock && !DENSITY_128) begin
                            pm_d[`FCR_PM_TB] = pm_q[`FCR_PM_TB]
                                & dat_q[`FCR_PM_TB];
                        end
                    end
                end
                `FCR_OP_WR_BOOT: begin
                    boot_d = dat_q;
                end
                default: boot_d = boot_q;
            endcase
        end
        // set wins over clear; flags never block decode
        err_d = err_q;
        if ((exec_ok && op_q == `FCR_OP_CLR_ERR) || sw_reset) begin
            err_d = '0;
        end
        err_d.prot = err_d.prot | err_event.prot | pm_fail;
        err_d.prog = err_d.prog | err_event.prog | pm_fail;
        err_d.erase = err_d.erase | err_event.erase;
        if (boot_start_delay == `FCR_DLY_DEFAULT) begin
            dly_d = quad_enable_bit ? `FCR_DLY_QUAD : `FCR_DLY_FAST;
        end else begin
            dly_d = boot_start_delay;
        end
        if (bank_v_q[`FCR_BA_MODE]) begin
            addr_hi_d = 8'h00;
        end else begin
            addr_hi_d = {7'h00, bank_v_q[`FCR_BA_SEG]};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bank_v_q <= `FCR_BANK_RST;
            bank_nv_q <= `FCR_BANK_RST;
            pm_q <= `FCR_PM_RST;
            boot_q <= `FCR_BOOT_RST;
            err_q <= '0;
            dly_q <= `FCR_DLY_FAST;
            addr_hi_q <= 8'h00;
        end else begin
            bank_v_q <= bank_v_d;
            bank_nv_q <= bank_nv_d;
            pm_q <= pm_d;
            boot_q <= boot_d;
            err_q <= err_d;
            dly_q <= dly_d;
            addr_hi_q <= addr_hi_d;
        end
    end

    // ==========================================================
    // outputs
    assign so = so_q;
    assign so_oe = oe_q;
    assign err_flags = err_q;
    assign boot_start_address = boot_q[31:`FCR_BOOT_ADR_LO];
    assign boot_start_delay = boot_q[`FCR_BOOT_DLY_HI:`FCR_BOOT_DLY_LO];
    assign boot_delay_cycles = dly_q;
    assign boot_read_enable = boot_q[`FCR_BOOT_EN];
    assign address_mode_bit = bank_v_q[`FCR_BA_MODE];
    assign upper_segment_select = bank_v_q[`FCR_BA_SEG];
    assign upper_address_bits = addr_hi_q;
    assign persistent_mode_lock = pm_q[`FCR_PM_PST];
    assign password_mode_lock = pm_q[`FCR_PM_PWD];
    assign parameter_sector_location = pm_q[`FCR_PM_TB];
endmodule

// *** verif/fcr_top_chk.sv ***
// concurrent checks on the ports of the flash config register bank
`timescale 1ns/1ps
module fcr_top_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic so_oe,
    input wire logic quad_enable_bit,
    input wire logic freeze_lock,
    input wire logic sw_reset,
    input wire fcr_pkg::fcr_err_t err_event,
    input wire fcr_pkg::fcr_err_t err_flags,
    input wire logic [3:0] boot_start_delay,
    input wire logic [3:0] boot_delay_cycles,
    input wire logic address_mode_bit,
    input wire logic upper_segment_select,
    input wire logic [7:0] upper_address_bits,
    input wire logic persistent_mode_lock,
    input wire logic password_mode_lock,
    input wire logic parameter_sector_location
);
    // ==========================================
    // properties
    logic [2:0] otp_bits;
    assign otp_bits = {parameter_sector_location, password_mode_lock,
                       persistent_mode_lock};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_err_hold;
        |($past(err_flags) & ~err_flags) |-> $past(sw_reset) || $past(cs_n);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("flag drop");
    property p_err_set;
        (err_event != 3'h0) && !sw_reset && cs_n && $past(cs_n, 4)
        |=> (err_flags & $past(err_event)) == $past(err_event);
    endproperty
    a_err_set: assert property (p_err_set) else $error("flag not set");
    property p_err_swr;
        sw_reset |=> err_flags == 3'h0;
    endproperty
    a_err_swr: assert property (p_err_swr) else $error("flags kept");
    property p_dly;
        boot_delay_cycles == (($past(boot_start_delay) != 4'h0) ?
            $past(boot_start_delay) : ($past(quad_enable_bit) ? 4'h6 : 4'h8));
    endproperty
    a_dly: assert property (p_dly) else $error("bad boot delay");
    property p_upper;
        upper_address_bits == ($past(address_mode_bit) ? 8'h00 :
            {7'h00, $past(upper_segment_select)});
    endproperty
    a_upper: assert property (p_upper) else $error("bad upper");
    property p_otp;
        (~$past(otp_bits) & otp_bits) == 3'h0;
    endproperty
    a_otp: assert property (p_otp) else $error("otp bit returned");
    property p_locks;
        persistent_mode_lock || password_mode_lock;
    endproperty
    a_locks: assert property (p_locks) else $error("both locks");
    property p_freeze;
        freeze_lock && $past(freeze_lock)
        |-> $stable(parameter_sector_location);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen bit");
    property p_mode;
        $changed(address_mode_bit) |-> $past(cs_n) || $past(sw_reset);
    endproperty
    a_mode: assert property (p_mode) else $error("mode mid frame");
    property p_oe_idle;
        cs_n [*6] |-> !so_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("so idle");
    c_err: cover property (err_flags.prog);
    c_mode: cover property ($rose(address_mode_bit));
    c_read: cover property ($rose(so_oe));
endmodule

bind fcr_top fcr_top_chk u_chk (
    .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .so_oe(so_oe),
    .quad_enable_bit(quad_enable_bit), .freeze_lock(freeze_lock),
    .sw_reset(sw_reset), .err_event(err_event), .err_flags(err_flags),
    .boot_start_delay(boot_start_delay),
    .boot_delay_cycles(boot_delay_cycles),
    .address_mode_bit(address_mode_bit),
    .upper_segment_select(upper_segment_select),
    .upper_address_bits(upper_address_bits),
    .persistent_mode_lock(persistent_mode_lock),
    .password_mode_lock(password_mode_lock),
    .parameter_sector_location(parameter_sector_location)
);

// *** verif/fcr_host_model.sv ***
// serial host model issuing register command frames
`timescale 1ns/1ps
module fcr_host_model (
    input wire logic ref_clk,
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    // ==========================================
    // frame tasks, clock idles low between frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        si <= b;
        repeat (10) @(posedge ref_clk);
        sck <= 1'b1;
        r = so;
        repeat (10) @(posedge ref_clk);
        sck <= 1'b0;
    endtask
    // bytes msb first, multi-byte values least significant byte first
    task automatic frame(input logic [7:0] op, input logic [31:0] wd,
                         input int nb, output logic [31:0] rd);
        logic r;
        rd = 32'h0;
        cs_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        for (int i = 7; i >= 0; i--) bit_io(op[i], r);
        for (int i = 0; i < 8 * nb; i++) begin
            bit_io(wd[8 * (i / 8) + 7 - i % 8], r);
            rd[8 * (i / 8) + 7 - i % 8] = r;
        end
        repeat (10) @(posedge ref_clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (10) @(posedge ref_clk);
    endtask
endmodule

// *** verif/test_flash_config_register_bank.sv ***
// self-checking bench of the flash config register bank
`timescale 1ns/1ps
module test_flash_config_register_bank;
    typedef struct {
        logic [7:0] op;
        logic [31:0] wd;
        int nw;
        logic fz;
        logic [7:0] rop;
        logic [31:0] exp;
    } fcr_row_t;
    // ==========================================
    // stimulus rows: write frame, then read back
    fcr_row_t rows [0:13] = '{
        '{8'h00, 32'h0, 0, 1'b0, 8'h16, 32'h0},
        '{8'h00, 32'h0, 0, 1'b0, 8'h2B, 32'hFFFF},
        '{8'h00, 32'h0, 0, 1'b0, 8'h14, 32'h0},
        '{8'h17, 32'h81, 1, 1'b0, 8'h16, 32'h81},
        '{8'hC5, 32'hFF, 1, 1'b0, 8'hC8, 32'h81},
        '{8'h29, 32'h0, 0, 1'b0, 8'h16, 32'h01},
        '{8'hB7, 32'h0, 0, 1'b0, 8'h16, 32'h81},
        '{8'h18, 32'h01, 1, 1'b0, 8'h16, 32'h01},
        '{8'h15, 32'h12345679, 4, 1'b0, 8'h14, 32'h12345679},
        '{8'h2F, 32'hFFFD, 2, 1'b0, 8'h2B, 32'hFFFD},
        '{8'h2F, 32'hFFFB, 2, 1'b0, 8'h2B, 32'hFFFD},
        '{8'h2F, 32'h7FFF, 2, 1'b1, 8'h2B, 32'hFFFD},
        '{8'h2F, 32'h7FFF, 2, 1'b0, 8'h2B, 32'h7FFD},
        '{8'h2F, 32'hFFFF, 2, 1'b0, 8'h2B, 32'h7FFD}};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic quad_en = 1'b0;
    logic oe;
    logic oe_seen = 1'b0;
    logic fz = 1'b0;
    logic sw_reset = 1'b0;
    fcr_pkg::fcr_err_t err_event = 3'h0;
    fcr_pkg::fcr_err_t err_flags;
    logic sck, cs_n, si, so;
    logic [26:0] bsa;
    logic [3:0] bsd, bdc;
    logic ben, amode, seg, pst, pwd, tbp;
    logic [7:0] upper;
    logic [31:0] rd;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (oe) begin
            oe_seen <= 1'b1;
        end
    end
    fcr_host_model host (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n),
                         .si(si), .so(so));
    fcr_top #(.DENSITY_128(1'b0)) uut (
        .ref_clk(ref_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so), .so_oe(oe), .quad_enable_bit(quad_en), .freeze_lock(fz),
        .sw_reset(sw_reset), .err_event(err_event), .err_flags(err_flags),
        .boot_start_address(bsa), .boot_start_delay(bsd),
        .boot_delay_cycles(bdc), .boot_read_enable(ben),
        .address_mode_bit(amode), .upper_segment_select(seg),
        .upper_address_bits(upper), .persistent_mode_lock(pst),
        .password_mode_lock(pwd), .parameter_sector_location(tbp));
    task chk_rd(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t read %h exp %h", $time, got, exp);
        end
    endtask
    task chk_port(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t port %h exp %h", $time, got, exp);
        end
    endtask
    function automatic int nrd(input logic [7:0] op);
        return (op == 8'h2B) ? 2 : ((op == 8'h14) ? 4 : 1);
    endfunction
    task pulse_err(input logic [2:0] ev);
        err_event <= ev;
        @(posedge ref_clk);
        err_event <= 3'h0;
        repeat (3) @(posedge ref_clk);
    endtask
    task test_done;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 50000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk_port({28'h0, bdc}, 32'h8);
        foreach (rows[i]) begin
            fz <= rows[i].fz;
            host.frame(rows[i].op, rows[i].wd, rows[i].nw, rd);
            host.frame(rows[i].rop, 32'h0, nrd(rows[i].rop), rd);
            chk_rd(rd, rows[i].exp);
        end
        chk_port({30'h0, oe_seen, oe}, 32'h2);
        chk_port({29'h0, err_flags}, 32'h6);
        chk_port({22'h0, amode, seg, upper}, 32'h101);
        chk_port({bsa, bsd, ben}, 32'h12345679);
        chk_port({28'h0, bdc}, 32'hC);
        chk_port({29'h0, tbp, pwd, pst}, 32'h2);
        host.frame(8'h82, 32'h0, 0, rd);
        chk_port({29'h0, err_flags}, 32'h0);
        pulse_err(3'h1);
        host.frame(8'h16, 32'h0, 1, rd);
        chk_port({29'h0, err_flags}, 32'h1);
        host.frame(8'h17, 32'h80, 1, rd);
        chk_port({22'h0, amode, seg, upper}, 32'h200);
        sw_reset <= 1'b1;
        @(posedge ref_clk);
        sw_reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_port({29'h0, err_flags}, 32'h0);
        host.frame(8'h16, 32'h0, 1, rd);
        chk_rd(rd, 32'h01);
        host.frame(8'h15, 32'h0, 4, rd);
        chk_port({28'h0, bdc}, 32'h8);
        quad_en <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk_port({28'h0, bdc}, 32'h6);
        quad_en <= 1'b0;
        pulse_err(3'h4);
        chk_port({29'h0, err_flags}, 32'h4);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk_port({29'h0, err_flags}, 32'h0);
        host.frame(8'h16, 32'h0, 1, rd);
        chk_rd(rd, 32'h0);
        test_done();
    end
endmodule
